//--- sfrm_top.sv
// Purpose: Special function register file behind an AHB-Lite slave
// Assumes: One bus master, word transfers, one system clock
// Notes:   Reads take one wait state, writes none
// Functional notes
// - Core registers answer at both bank addresses
// - Upper counter bits have no register address
// - Counter loads take upper bits from holding
// - Power-on and other resets give distinct values
`timescale 1ns/100ps
`default_nettype none
`include "sfrm_regs.svh"

module sfrm_top (
  input  wire logic        hclk,           // System clock
  input  wire logic        hresetn,        // Power-on or brown-out reset, active low
  input  wire logic        hsel,           // Slave select
  input  wire logic [31:0] haddr,          // Byte address
  input  wire logic [1:0]  htrans,         // Transfer type
  input  wire logic        hwrite,         // Write when high
  input  wire logic [2:0]  hsize,          // Transfer size
  input  wire logic [31:0] hwdata,         // Write data
  input  wire logic        hready,         // Bus ready
  output logic             hreadyout,      // Slave ready
  output logic             hresp,          // Always OKAY
  output logic      [31:0] hrdata,         // Read data
  input  wire logic        sys_reset_req,  // Pin or watchdog reset pulse
  input  wire logic        sys_reset_wdt,  // Reset came from the watchdog
  input  wire logic        core_step,      // Counter advance pulse
  input  wire logic        core_jump,      // Counter branch pulse
  input  wire logic [7:0]  core_jump_low,  // Branch target low byte
  output logic      [12:0] pc_value,       // Program counter
  input  wire logic [2:0]  irq_flag_set,   // Interrupt flag set pulses
  input  wire logic        rx_strobe,      // Received byte pulse
  input  wire logic [7:0]  rx_byte,        // Received byte
  input  wire logic [2:0]  rx_status,      // Frame err, overrun, ninth bit
  output logic             bank_select,    // Direct bank select bit
  output logic      [7:0]  presc_options,  // Prescaler and edge options
  output logic      [5:0]  dir_a,          // Port A direction
  output logic      [7:0]  dir_b,          // Port B direction
  output logic      [7:0]  dir_c,          // Port C direction
  output logic      [7:0]  irq_control,    // Interrupt control
  output logic      [7:0]  tx_byte,        // Transmit data
  output logic             tx_load         // Transmit data written pulse
);

  localparam int SLOTS = `SFRM_SLOTS;

  localparam logic [7:0] OFS [SLOTS] = '{
    `SFRM_OFS_T1_CNT_HI, `SFRM_OFS_T1_CTRL, `SFRM_OFS_T2_CNT, `SFRM_OFS_T2_CTRL,
    `SFRM_OFS_SS_BUF, `SFRM_OFS_SS_CTRL, `SFRM_OFS_CCP1_LO, `SFRM_OFS_CCP1_HI,
    `SFRM_OFS_CCP1_CTRL, `SFRM_OFS_RX_CTRL, `SFRM_OFS_TX_DATA, `SFRM_OFS_RX_DATA,
    `SFRM_OFS_CCP2_LO, `SFRM_OFS_CCP2_HI, `SFRM_OFS_CCP2_CTRL, `SFRM_OFS_PRESC_OPT,
    `SFRM_OFS_CORE_FLAGS, `SFRM_OFS_IND_PTR, `SFRM_OFS_DIR_A, `SFRM_OFS_DIR_B,
    `SFRM_OFS_DIR_C, `SFRM_OFS_HOLD, `SFRM_OFS_PERIPHERAL_IRQ_ENABLE1
  };

  // Power-on values
  localparam logic [7:0] RST [SLOTS] = '{
    `SFRM_RST_ZERO, `SFRM_RST_ZERO, `SFRM_RST_ZERO, `SFRM_RST_ZERO,
    `SFRM_RST_ZERO, `SFRM_RST_ZERO, `SFRM_RST_ZERO, `SFRM_RST_ZERO,
    `SFRM_RST_ZERO, `SFRM_RST_ZERO, `SFRM_RST_ZERO, `SFRM_RST_ZERO,
    `SFRM_RST_ZERO, `SFRM_RST_ZERO, `SFRM_RST_ZERO, `SFRM_RST_PRESC_OPT,
    `SFRM_RST_CORE_FLAGS, `SFRM_RST_ZERO, `SFRM_RST_DIR_A, `SFRM_RST_DIR_B,
    `SFRM_RST_DIR_C, `SFRM_RST_ZERO, `SFRM_RST_ZERO
  };

  // Bits software may write; the rest read zero or hold hardware state
  localparam logic [7:0] WMASK [SLOTS] = '{
    8'hFF, 8'h3F, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'h3F, 8'hF0, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h3F, 8'hFF,
    8'hE7, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h1F, 8'hFF
  };

  // Bits left unchanged by a pin or watchdog reset
  localparam logic [7:0] KEEP [SLOTS] = '{
    8'hFF, 8'h3F, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF,
    8'h00, 8'h01, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00,
    8'h1F, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };

  localparam logic [7:0] IRQ_KEEP   = 8'h01;
  localparam logic [7:0] IRQ_WMASK  = 8'hFF;
  localparam logic [7:0] FLAG_TOPD  = 8'((1 << `SFRM_FLAG_TO) | (1 << `SFRM_FLAG_PD));
  localparam logic [7:0] FLAG_PD    = 8'(1 << `SFRM_FLAG_PD);

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase tracking

  sfrm_pkg::sfrm_phase_t phase_r;
  sfrm_pkg::sfrm_phase_t phase_nxt;
  logic [7:0]            addr_r;
  logic [7:0]            addr_nxt;
  logic                  ok_r;
  logic                  ok_nxt;
  logic [31:0]           hrdata_r;
  logic [31:0]           hrdata_nxt;
  logic                  accept;
  logic [7:0]            rd_val;

  assign accept = hsel && hready && htrans[1];

  always_comb
  begin
    phase_nxt  = sfrm_pkg::SFRM_PH_IDLE;
    addr_nxt   = addr_r;
    ok_nxt     = ok_r;
    hrdata_nxt = hrdata_r;
    case (phase_r)
      sfrm_pkg::SFRM_PH_RD1:
      begin
        phase_nxt  = sfrm_pkg::SFRM_PH_RD2;
        hrdata_nxt = {24'h000000, rd_val};
      end
      sfrm_pkg::SFRM_PH_IDLE, sfrm_pkg::SFRM_PH_WR, sfrm_pkg::SFRM_PH_RD2:
      begin
        if (accept)
        begin
          phase_nxt = hwrite ? sfrm_pkg::SFRM_PH_WR : sfrm_pkg::SFRM_PH_RD1;
          addr_nxt  = haddr[9:2];
          ok_nxt    = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0)
                      && (hsize == `SFRM_HSIZE_WORD);
        end
      end
      default:
      begin
        phase_nxt = sfrm_pkg::SFRM_PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_r  <= sfrm_pkg::SFRM_PH_IDLE;
      addr_r   <= 8'h00;
      ok_r     <= 1'b0;
      hrdata_r <= 32'h00000000;
    end
    else
    begin
      phase_r  <= phase_nxt;
      addr_r   <= addr_nxt;
      ok_r     <= ok_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  assign hreadyout = (phase_r != sfrm_pkg::SFRM_PH_RD1);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode with bank mirroring and indirect access

  logic [7:0] file_r   [SLOTS];
  logic [7:0] file_nxt [SLOTS];
  logic [7:0] irq_r;
  logic [7:0] irq_nxt;
  logic [7:0] eff_addr;
  logic [4:0] hit_slot;
  logic       hit;
  logic       pc_hit;
  logic       irq_hit;
  logic       wr_act;
  logic [7:0] wr_data;

  // Maps a bank 0 alias of a shared register to its single address
  function automatic logic [7:0] sfrm_canon(input logic [7:0] a);
    logic [7:0] b;
    b = {1'b1, a[6:0]};
    if ((b == `SFRM_OFS_IND_PORT) || (b == `SFRM_OFS_PC_LOW) ||
        (b == `SFRM_OFS_CORE_FLAGS) || (b == `SFRM_OFS_IND_PTR) ||
        (b == `SFRM_OFS_HOLD) || (b == `SFRM_OFS_IRQ_CTRL))
    begin
      return b;
    end
    return a;
  endfunction

  always_comb
  begin
    eff_addr = sfrm_canon(addr_r);
    if (eff_addr == `SFRM_OFS_IND_PORT)
    begin
      eff_addr = sfrm_canon(file_r[sfrm_pkg::SFRM_S_IND_PTR]);
    end
    hit      = 1'b0;
    hit_slot = 5'h00;
    for (int i = 0; i < SLOTS; i++)
    begin
      if (eff_addr == OFS[i])
      begin
        hit      = ok_r;
        hit_slot = 5'(i);
      end
    end
    // Counter upper bits have no address, only its low byte decodes
    pc_hit  = ok_r && (eff_addr == `SFRM_OFS_PC_LOW);
    irq_hit = ok_r && (eff_addr == `SFRM_OFS_IRQ_CTRL);
  end

  assign wr_act  = (phase_r == sfrm_pkg::SFRM_PH_WR);
  assign wr_data = hwdata[7:0];

  always_comb
  begin
    rd_val = 8'h00;
    if (pc_hit)
    begin
      rd_val = pc_value[7:0];
    end
    else if (irq_hit)
    begin
      rd_val = irq_r;
    end
    else if (hit && (hit_slot != sfrm_pkg::SFRM_S_TX_DATA))
    begin
      rd_val = file_r[hit_slot];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] hw_mask [SLOTS];
  logic [7:0] hw_val  [SLOTS];

  // Hardware loads applied over the software value
  always_comb
  begin
    for (int i = 0; i < SLOTS; i++)
    begin
      hw_mask[i] = 8'h00;
      hw_val[i]  = 8'h00;
    end
    if (rx_strobe)
    begin
      hw_mask[sfrm_pkg::SFRM_S_RX_CTRL] = 8'h07;
      hw_val[sfrm_pkg::SFRM_S_RX_CTRL]  = {5'h00, rx_status};
      hw_mask[sfrm_pkg::SFRM_S_RX_DATA] = 8'hFF;
      hw_val[sfrm_pkg::SFRM_S_RX_DATA]  = rx_byte;
    end
    if (sys_reset_req && sys_reset_wdt)
    begin
      hw_mask[sfrm_pkg::SFRM_S_CORE_FLAGS] = FLAG_TOPD;
      hw_val[sfrm_pkg::SFRM_S_CORE_FLAGS]  = FLAG_PD;
    end
  end

  for (genvar s = 0; s < SLOTS; s++)
  begin : g_slot
    always_comb
    begin
      file_nxt[s] = file_r[s];
      if (sys_reset_req)
      begin
        file_nxt[s] = (file_r[s] & KEEP[s]) | (RST[s] & ~KEEP[s]);
      end
      else if (wr_act && hit && (hit_slot == 5'(s)))
      begin
        file_nxt[s] = (file_r[s] & ~WMASK[s]) | (wr_data & WMASK[s]);
      end
      file_nxt[s] = (file_nxt[s] & ~hw_mask[s]) | (hw_val[s] & hw_mask[s]);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        file_r[s] <= RST[s];
      end
      else
      begin
        file_r[s] <= file_nxt[s];
      end
    end
  end

  // Interrupt control: flag set wins over a clearing write
  always_comb
  begin
    irq_nxt = irq_r;
    if (sys_reset_req)
    begin
      irq_nxt = irq_r & IRQ_KEEP;
    end
    else if (wr_act && irq_hit)
    begin
      irq_nxt = wr_data & IRQ_WMASK;
    end
    irq_nxt = irq_nxt | {5'h00, irq_flag_set};
  end

  logic tx_load_r;
  logic tx_load_nxt;

  assign tx_load_nxt = wr_act && hit && !sys_reset_req
                       && (hit_slot == sfrm_pkg::SFRM_S_TX_DATA);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_r     <= `SFRM_RST_ZERO;
      tx_load_r <= 1'b0;
    end
    else
    begin
      irq_r     <= irq_nxt;
      tx_load_r <= tx_load_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and outputs

  sfrm_pc i_sfrm_pc (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .soft_rst      (sys_reset_req),
    .core_step     (core_step),
    .core_jump     (core_jump),
    .core_jump_low (core_jump_low),
    .sw_load       (wr_act && pc_hit && !sys_reset_req),
    .sw_low        (wr_data),
    .holding       (file_r[sfrm_pkg::SFRM_S_HOLD][4:0]),
    .pc_value      (pc_value)
  );

  assign bank_select   = file_r[sfrm_pkg::SFRM_S_CORE_FLAGS][`SFRM_FLAG_BANK0];
  assign presc_options = file_r[sfrm_pkg::SFRM_S_PRESC_OPT];
  assign dir_a         = file_r[sfrm_pkg::SFRM_S_DIR_A][5:0];
  assign dir_b         = file_r[sfrm_pkg::SFRM_S_DIR_B];
  assign dir_c         = file_r[sfrm_pkg::SFRM_S_DIR_C];
  assign irq_control   = irq_r;
  assign tx_byte       = file_r[sfrm_pkg::SFRM_S_TX_DATA];
  assign tx_load       = tx_load_r;

endmodule

`default_nettype wire

//--- sfrm_regs.svh
// Purpose: Offsets, reset values and field positions of the register map
// Assumes: Offsets are register indices; byte address is four times the index
// Notes:   Values that power up unknown are given zero here
`ifndef SFRM_REGS_SVH
`define SFRM_REGS_SVH

`define SFRM_SLOTS          23
`define SFRM_HSIZE_WORD     3'h2
`define SFRM_BANK_BIT       7

`define SFRM_OFS_T1_CNT_HI  8'h0F
`define SFRM_OFS_T1_CTRL    8'h10
`define SFRM_OFS_T2_CNT     8'h11
`define SFRM_OFS_T2_CTRL    8'h12
`define SFRM_OFS_SS_BUF     8'h13
`define SFRM_OFS_SS_CTRL    8'h14
`define SFRM_OFS_CCP1_LO    8'h15
`define SFRM_OFS_CCP1_HI    8'h16
`define SFRM_OFS_CCP1_CTRL  8'h17
`define SFRM_OFS_RX_CTRL    8'h18
`define SFRM_OFS_TX_DATA    8'h19
`define SFRM_OFS_RX_DATA    8'h1A
`define SFRM_OFS_CCP2_LO    8'h1B
`define SFRM_OFS_CCP2_HI    8'h1C
`define SFRM_OFS_CCP2_CTRL  8'h1D
`define SFRM_OFS_IND_PORT   8'h80
`define SFRM_OFS_PRESC_OPT  8'h81
`define SFRM_OFS_PC_LOW     8'h82
`define SFRM_OFS_CORE_FLAGS 8'h83
`define SFRM_OFS_IND_PTR    8'h84
`define SFRM_OFS_DIR_A      8'h85
`define SFRM_OFS_DIR_B      8'h86
`define SFRM_OFS_DIR_C      8'h87
`define SFRM_OFS_HOLD       8'h8A
`define SFRM_OFS_IRQ_CTRL   8'h8B
`define SFRM_OFS_PERIPHERAL_IRQ_ENABLE1       8'h8C

`define SFRM_RST_ZERO       8'h00
`define SFRM_RST_PRESC_OPT  8'hFF
`define SFRM_RST_CORE_FLAGS 8'h18
`define SFRM_RST_DIR_A      8'h3F
`define SFRM_RST_DIR_B      8'hFF
`define SFRM_RST_DIR_C      8'hFF
`define SFRM_RST_PC         13'h0000

`define SFRM_FLAG_BANK0     5
`define SFRM_FLAG_TO        4
`define SFRM_FLAG_PD        3

`endif

//--- sfrm_pkg.sv
// Purpose: Types used by the register map: slot codes and bus phases
// Assumes: Slot codes follow the order of the offset table
// Notes:   Slots cover only registers with storage of their own
package sfrm_pkg;

  typedef enum logic [4:0] {
    SFRM_S_T1_CNT_HI  = 5'h00,
    SFRM_S_T1_CTRL    = 5'h01,
    SFRM_S_T2_CNT     = 5'h02,
    SFRM_S_T2_CTRL    = 5'h03,
    SFRM_S_SS_BUF     = 5'h04,
    SFRM_S_SS_CTRL    = 5'h05,
    SFRM_S_CCP1_LO    = 5'h06,
    SFRM_S_CCP1_HI    = 5'h07,
    SFRM_S_CCP1_CTRL  = 5'h08,
    SFRM_S_RX_CTRL    = 5'h09,
    SFRM_S_TX_DATA    = 5'h0A,
    SFRM_S_RX_DATA    = 5'h0B,
    SFRM_S_CCP2_LO    = 5'h0C,
    SFRM_S_CCP2_HI    = 5'h0D,
    SFRM_S_CCP2_CTRL  = 5'h0E,
    SFRM_S_PRESC_OPT  = 5'h0F,
    SFRM_S_CORE_FLAGS = 5'h10,
    SFRM_S_IND_PTR    = 5'h11,
    SFRM_S_DIR_A      = 5'h12,
    SFRM_S_DIR_B      = 5'h13,
    SFRM_S_DIR_C      = 5'h14,
    SFRM_S_HOLD       = 5'h15,
    SFRM_S_PERIPHERAL_IRQ_ENABLE1       = 5'h16
  } sfrm_slot_t;

  typedef enum logic [1:0] {
    SFRM_PH_IDLE = 2'b00,
    SFRM_PH_WR   = 2'b01,
    SFRM_PH_RD1  = 2'b10,
    SFRM_PH_RD2  = 2'b11
  } sfrm_phase_t;

endpackage

//--- sfrm_pc.sv
// Purpose: Program counter with upper bits loaded from the holding register
// Assumes: Core step and jump strobes are one-cycle pulses
// Notes:   Upper counter bits have no direct access path
`timescale 1ns/100ps
`default_nettype none
`include "sfrm_regs.svh"

module sfrm_pc (
  input  wire logic        hclk,          // System clock
  input  wire logic        hresetn,       // Power-on reset, active low
  input  wire logic        soft_rst,      // Pin or watchdog reset pulse
  input  wire logic        core_step,     // Advance by one
  input  wire logic        core_jump,     // Core branch load
  input  wire logic [7:0]  core_jump_low, // Branch target low byte
  input  wire logic        sw_load,       // Software write of low byte
  input  wire logic [7:0]  sw_low,        // Written low byte
  input  wire logic [4:0]  holding,       // Holding register contents
  output logic      [12:0] pc_value       // Counter value
);

  logic [12:0] pc_r;
  logic [12:0] pc_nxt;

  always_comb
  begin
    pc_nxt = pc_r;
    if (soft_rst)
    begin
      pc_nxt = `SFRM_RST_PC;
    end
    else if (sw_load)
    begin
      pc_nxt = {holding, sw_low};
    end
    else if (core_jump)
    begin
      pc_nxt = {holding, core_jump_low};
    end
    else if (core_step)
    begin
      pc_nxt = pc_r + 13'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pc_r <= `SFRM_RST_PC;
    end
    else
    begin
      pc_r <= pc_nxt;
    end
  end

  assign pc_value = pc_r;

endmodule

`default_nettype wire

//--- sfrm_top_sva.sv
// Purpose: Port-level checks on the register file
// Assumes: Register index is haddr[9:2], byte address four times the index
// Notes:   Bound to every instance of the top module
`timescale 1ns/100ps
`default_nettype none

module sfrm_top_chk (
  input wire logic        hclk,          // Clock
  input wire logic        hresetn,       // Reset, active low
  input wire logic        hsel,          // Select
  input wire logic [31:0] haddr,         // Address
  input wire logic [1:0]  htrans,        // Transfer type
  input wire logic        hwrite,        // Write
  input wire logic [2:0]  hsize,         // Size
  input wire logic [31:0] hwdata,        // Write data
  input wire logic        hready,        // Bus ready
  input wire logic        hreadyout,     // Slave ready
  input wire logic        hresp,         // Response
  input wire logic [31:0] hrdata,        // Read data
  input wire logic        sys_reset_req, // Soft reset
  input wire logic        core_step,     // Advance
  input wire logic        core_jump,     // Branch
  input wire logic [7:0]  core_jump_low, // Branch low byte
  input wire logic [12:0] pc_value,      // Counter
  input wire logic        bank_select,   // Bank bit
  input wire logic [7:0]  presc_options, // Options
  input wire logic [7:0]  dir_b,         // Port B direction
  input wire logic [7:0]  tx_byte,       // Transmit data
  input wire logic        tx_load        // Transmit pulse
);
  logic acc;
  logic wr_pc_r;
  logic wr_pc_nxt;

  assign acc = hsel && hready && htrans[1] && hsize == 3'h2;
  assign wr_pc_nxt = acc && hwrite && (haddr == 32'h8 || haddr == 32'h208);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wr_pc_r <= 1'b0;
    else
      wr_pc_r <= wr_pc_nxt;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_req;
    acc && !hwrite;
  endsequence
  sequence s_wait_state;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_wr_tx;
    acc && hwrite && haddr == 32'h64;
  endsequence

  property p_rd_wait;
    s_rd_req |=> s_wait_state;
  endproperty
  property p_hresp;
    hresp == 1'b0;
  endproperty
  property p_unmapped_rd;
    s_rd_req and (haddr == 32'h220) |=> ##1 hrdata == 32'h0;
  endproperty
  property p_flags_mirror;
    acc && hwrite && (haddr == 32'hC || haddr == 32'h20C)
      |=> sys_reset_req or ##1 (bank_select == $past(hwdata[5]));
  endproperty
  property p_tx;
    s_wr_tx |=> sys_reset_req or ##1 (tx_load && tx_byte == $past(hwdata[7:0]));
  endproperty
  property p_tx_cause;
    tx_load |-> $past(acc && hwrite && haddr == 32'h64, 2);
  endproperty
  property p_step;
    core_step && !core_jump && !wr_pc_r && !sys_reset_req
      |=> pc_value == $past(pc_value) + 13'h1;
  endproperty
  property p_jump;
    core_jump && !wr_pc_r && !sys_reset_req |=> pc_value[7:0] == $past(core_jump_low);
  endproperty
  property p_upper_stable;
    !core_jump && !wr_pc_r && !sys_reset_req && !(core_step && pc_value[7:0] == 8'hFF)
      |=> $stable(pc_value[12:8]);
  endproperty
  property p_sys_rst;
    sys_reset_req |=> pc_value == 13'h0 && presc_options == 8'hFF && dir_b == 8'hFF
      && !bank_select && tx_byte == 8'h0;
  endproperty

  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  a_hresp: assert property (p_hresp) else $error("response not okay");
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  a_flags_mirror: assert property (p_flags_mirror) else $error("bank bit not written");
  a_tx: assert property (p_tx) else $error("transmit write not seen");
  a_tx_cause: assert property (p_tx_cause) else $error("transmit pulse without write");
  a_step: assert property (p_step) else $error("counter step wrong");
  a_jump: assert property (p_jump) else $error("counter branch wrong");
  a_upper_stable: assert property (p_upper_stable) else $error("upper counter moved");
  a_sys_rst: assert property (p_sys_rst) else $error("soft reset values wrong");
endmodule

bind sfrm_top sfrm_top_chk i_sfrm_top_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .sys_reset_req, .core_step, .core_jump,
  .core_jump_low, .pc_value, .bank_select, .presc_options, .dir_b, .tx_byte, .tx_load);

`default_nettype wire

//--- sfrm_tb.sv
// Purpose: Self-checking bench for the register file
// Assumes: Bus master keeps single word transfers
// Notes:   Receive and interrupt-flag inputs stay idle
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        sys_reset_req, sys_reset_wdt, core_step, core_jump, bank_select, tx_load;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  core_jump_low, presc_options, dir_b, dir_c, irq_control, tx_byte;
  logic [5:0]  dir_a;
  logic [12:0] pc_value;
  int          err_count;
  int          checks;

  assign hready = hreadyout;

  sfrm_top i_sfrm_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .sys_reset_req, .sys_reset_wdt, .core_step,
    .core_jump, .core_jump_low, .pc_value, .irq_flag_set(3'h0), .rx_strobe(1'b0),
    .rx_byte(8'h00), .rx_status(3'h0), .bank_select, .presc_options, .dir_a, .dir_b, .dir_c,
    .irq_control, .tx_byte, .tx_load);

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    checks++;
    if (got !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic wait_rdy(output logic [31:0] rd);
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        err_count++;
        stop_test();
      end
      @(negedge hclk);
    end
    rd = hrdata;
    @(posedge hclk);
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    logic [31:0] tmp;
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy(tmp);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy(rd);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk(what, {24'h0, e}, x);
  endtask

  // Kind 0 step, 1 branch, 2 pin reset, 3 watchdog reset
  task automatic pulse(input logic [1:0] kind, input logic [7:0] low);
    core_step     <= kind == 2'h0;
    core_jump     <= kind == 2'h1;
    sys_reset_req <= kind[1];
    sys_reset_wdt <= kind[0];
    core_jump_low <= low;
    @(posedge hclk);
    core_step     <= 1'b0;
    core_jump     <= 1'b0;
    sys_reset_req <= 1'b0;
    @(posedge hclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    logic [7:0] ix [0:16];
    logic [7:0] ev [0:16];
    ix = '{8'h10, 8'h11, 8'h12, 8'h14, 8'h17, 8'h19, 8'h1A, 8'h1D, 8'h80, 8'h81, 8'h82,
           8'h83, 8'h85, 8'h86, 8'h87, 8'h8A, 8'h8C};
    ev = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00,
           8'h18, 8'h3F, 8'hFF, 8'hFF, 8'h00, 8'h00};
    for (int i = 0; i < 17; i++)
      rdc("reset value", ix[i], ev[i]);
    chk("port values", 32'hFF3FFFFF, {presc_options, 2'h0, dir_a, dir_b, dir_c});
    chk("counter", 32'h0, {19'h0, pc_value});
    $display("t_reset_vals done");
  endtask

  task automatic t_mirror();
    wr(8'h04, 8'h5A);
    rdc("pointer", 8'h84, 8'h5A);
    wr(8'h8A, 8'hF3);
    rdc("holding", 8'h0A, 8'h13);
    wr(8'h03, 8'h27);
    rdc("flags", 8'h83, 8'h3F);
    chk("bank select", 32'h1, {31'h0, bank_select});
    wr(8'h83, 8'h00);
    rdc("flags", 8'h03, 8'h18);
    wr(8'h0B, 8'hA8);
    rdc("irq control", 8'h8B, 8'hA8);
    chk("irq port", 32'hA8, {24'h0, irq_control});
    wr(8'h8B, 8'h00);
    wr(8'h8C, 8'h3F);
    rdc("irq enable", 8'h8C, 8'h3F);
    wr(8'h84, 8'h86);
    rdc("indirect read", 8'h00, 8'hFF);
    wr(8'h80, 8'h00);
    @(negedge hclk);
    chk("indirect write", 32'h0, {24'h0, dir_b});
    @(posedge hclk);
    wr(8'h84, 8'h80);
    rdc("indirect self", 8'h00, 8'h00);
    wr(8'h86, 8'hFF);
    $display("t_mirror done");
  endtask

  task automatic t_counter();
    wr(8'h0A, 8'h15);
    wr(8'h02, 8'h34);
    @(negedge hclk);
    chk("counter load", 32'h1534, {19'h0, pc_value});
    @(posedge hclk);
    wr(8'h8A, 8'h0B);
    pulse(2'h1, 8'h7F);
    chk("counter branch", 32'h0B7F, {19'h0, pc_value});
    pulse(2'h0, 8'h00);
    chk("counter step", 32'h0B80, {19'h0, pc_value});
    rdc("counter low", 8'h82, 8'h80);
    wr(8'h82, 8'hFF);
    pulse(2'h0, 8'h00);
    chk("counter carry", 32'h0C00, {19'h0, pc_value});
    $display("t_counter done");
  endtask

  task automatic t_unmapped();
    wr(8'h88, 8'hFF);
    rdc("unmapped", 8'h88, 8'h00);
    wr(8'h1E, 8'hFF);
    rdc("unmapped", 8'h1E, 8'h00);
    wr(8'h1A, 8'h55);
    rdc("receive data", 8'h1A, 8'h00);
    wr(8'h19, 8'hC3);
    @(negedge hclk);
    chk("transmit", 32'h1C3, {23'h0, tx_load, tx_byte});
    @(posedge hclk);
    rdc("transmit read", 8'h19, 8'h00);
    $display("t_unmapped done");
  endtask

  task automatic t_sys_reset();
    wr(8'h86, 8'h00);
    wr(8'h81, 8'h00);
    wr(8'h84, 8'hA5);
    wr(8'h10, 8'h3F);
    wr(8'h8A, 8'h1F);
    wr(8'h03, 8'h02);
    wr(8'h19, 8'h66);
    pulse(2'h3, 8'h00);
    chk("ports", 32'h000000FF, {pc_value, 3'h0, tx_byte, dir_b});
    rdc("options", 8'h81, 8'hFF);
    rdc("pointer kept", 8'h84, 8'hA5);
    rdc("t1 control kept", 8'h10, 8'h3F);
    rdc("holding", 8'h8A, 8'h00);
    rdc("flags watchdog", 8'h03, 8'h0A);
    wr(8'h03, 8'h01);
    pulse(2'h2, 8'h00);
    rdc("flags pin", 8'h83, 8'h09);
    $display("t_sys_reset done");
  endtask

  initial
  begin
    err_count = 0;
    checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sys_reset_req = 1'b0;
    sys_reset_wdt = 1'b0;
    core_step = 1'b0;
    core_jump = 1'b0;
    core_jump_low = 8'h00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_vals();
    t_mirror();
    t_counter();
    t_unmapped();
    t_sys_reset();
    stop_test();
  end
endmodule

`default_nettype wire
